// ### design/frcm_top.sv
// Recovery counter supervisor and clock stop monitor with an AXI4-Lite register slave.
// Functional notes
// - Supervision starts when software sets the recovery enable and keeps running if the bit is later cleared.
// - The recovery counter starts only on a fault event or a resonator stop seen while supervision is active.
// - An error clear before overflow zeroes the counter and holds it until the next fault event or resonator stop.
// - Counter overflow sets the recovery overflow error bit.
// - The error register returns the recovery overflow error and a write to it clears the bit.
// - The counter period is 125 ms, 500 ms, 2 s or 4 s, with 2 s after reset.
// - Period and overflow action come from the configuration register; the action picks standby return.
// - A forced standby return clears every enable bit of the safety control register.
// - A forced standby return keeps the error bits and the fault output selection.
// - With detection enabled a resonator stop sets the clock stop error and selects the RC clock.
// - With detection disabled a resonator stop still selects the RC clock but leaves the error bit alone.
// - An error read arriving during the switchover holds the busy pin low; the host waits for it high.
// - Error clear leaves the clock stop error set while the resonator stays stopped and detection is enabled.
// - Fault indications are routed to the indicator pins as the output selection register says.
`timescale 1ns/100ps
`include "frcm_params.svh"
module frcm_top import frcm_pkg::*; #(
	parameter int unsigned PER_125_CYC = `FRCM_MS_CYC(`FRCM_T125_MS),
	parameter int unsigned PER_500_CYC = `FRCM_MS_CYC(`FRCM_T500_MS),
	parameter int unsigned PER_2S_CYC = `FRCM_MS_CYC(`FRCM_T2S_MS),
	parameter int unsigned PER_4S_CYC = `FRCM_MS_CYC(`FRCM_T4S_MS),
	parameter int unsigned SWITCH_CYC = `FRCM_SWITCH_CYC,
	parameter int unsigned STOP_CYC = `FRCM_OSC_STOP_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fault_event,
	input wire logic osc_clk_in,
	output logic command_busy_n,
	output logic use_rc_clock,
	output logic standby_return,
	output logic [1:0] fault_indicator_pin,
	output logic irq
);
	if (PER_125_CYC < 2 || PER_500_CYC < 2 || PER_2S_CYC < 2 || PER_4S_CYC < 2) begin : g_chk
		$error("frcm_top: counter periods must be at least two cycles");
	end

	frcm_osc_if osc ();

	frcm_osc_mon #(.STOP_CYC(STOP_CYC), .SWITCH_CYC(SWITCH_CYC)) u_osc (
		.ref_clk(ref_clk),
		.srst(srst),
		.osc_clk_in(osc_clk_in),
		.osc(osc)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic [7:0] aw_addr_reg, aw_addr_next, ar_addr_reg, ar_addr_next;
	logic [7:0] wdat_reg, wdat_next;
	logic wstb_reg, wstb_next;
	logic awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next, rd_word;
	logic rd_ok;
	frcm_rd_state_t rd_state_reg, rd_state_next;
	logic busy_n_reg, busy_n_next;
	logic [1:0] ctrl_reg, ctrl_next;
	logic [2:0] cfg_reg, cfg_next;
	logic [3:0] outsel_reg, outsel_next;
	frcm_err_t err_reg, err_next, ist_reg, ist_next, imask_reg, imask_next;
	logic sup_reg, sup_next, run_reg, run_next;
	logic [31:0] cnt_reg, cnt_next, lim;
	logic stby_reg, stby_next, irq_reg, irq_next, rc_reg;
	logic [1:0] pin_reg, pin_next;
	logic do_wr, wr_ctrl, wr_err, start, ovf, ovf_stby;

	// ----------------------------------------
	// Period selection and event terms
	// ----------------------------------------
	// period selection
	always_comb begin
		unique case (cfg_reg[`FRCM_CFG_PER_LSB +: 2])
			2'h0: lim = 32'(PER_125_CYC);
			2'h1: lim = 32'(PER_500_CYC);
			2'h2: lim = 32'(PER_2S_CYC);
			2'h3: lim = 32'(PER_4S_CYC);
		endcase
	end

	assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wr_ctrl = do_wr && wstb_reg && aw_addr_reg == `FRCM_REG_CTRL;
	assign wr_err = do_wr && aw_addr_reg == `FRCM_REG_ERR;
	assign start = sup_reg && (fault_event || osc.stop_pulse);
	assign ovf = run_reg && cnt_reg == lim - 32'h1;
	assign ovf_stby = ovf && cfg_reg[`FRCM_CFG_ACT_BIT];

	// ----------------------------------------
	// Read data selection
	// ----------------------------------------
	always_comb begin
		rd_word = 32'h0;
		rd_ok = 1'h1;
		unique case ((rd_state_reg == FRCM_RD_IDLE) ? s_axi_araddr : ar_addr_reg)
			`FRCM_REG_CTRL: rd_word = {30'h0, ctrl_reg};
			`FRCM_REG_CFG: rd_word = {29'h0, cfg_reg};
			`FRCM_REG_ERR: rd_word = {30'h0, err_reg};
			`FRCM_REG_OUTSEL: rd_word = {28'h0, outsel_reg};
			`FRCM_REG_IRQ_STAT: rd_word = {30'h0, ist_reg};
			`FRCM_REG_IRQ_MASK: rd_word = {30'h0, imask_reg};
			`FRCM_REG_STATE: rd_word = {28'h0, osc.switching, rc_reg, run_reg, sup_reg};
			default: rd_ok = 1'h0;
		endcase
	end

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	always_comb begin
		aw_full_next = aw_full_reg;
		w_full_next = w_full_reg;
		aw_addr_next = aw_addr_reg;
		wdat_next = wdat_reg;
		wstb_next = wstb_reg;
		ar_addr_next = ar_addr_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		rd_state_next = rd_state_reg;
		busy_n_next = busy_n_reg;
		ctrl_next = ctrl_reg;
		cfg_next = cfg_reg;
		outsel_next = outsel_reg;
		imask_next = imask_reg;
		err_next = err_reg;
		ist_next = ist_reg;
		sup_next = sup_reg;
		run_next = run_reg;
		cnt_next = cnt_reg;
		stby_next = 1'h0;
		// Address and data are taken independently, in either order.
		if (s_axi_awvalid && awready_reg) begin
			aw_full_next = 1'h1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			w_full_next = 1'h1;
			wdat_next = s_axi_wdata[7:0];
			wstb_next = s_axi_wstrb[0];
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'h0;
		end
		if (do_wr) begin
			aw_full_next = 1'h0;
			w_full_next = 1'h0;
			bvalid_next = 1'h1;
			bresp_next = `FRCM_RESP_OKAY;
			if (wstb_reg) begin
				unique case (aw_addr_reg)
					`FRCM_REG_CTRL: ctrl_next = wdat_reg[1:0];
					`FRCM_REG_CFG: cfg_next = wdat_reg[2:0];
					`FRCM_REG_OUTSEL: outsel_next = wdat_reg[3:0];
					`FRCM_REG_IRQ_STAT: ist_next = ist_reg & ~wdat_reg[1:0];
					`FRCM_REG_IRQ_MASK: imask_next = wdat_reg[1:0];
					`FRCM_REG_ERR, `FRCM_REG_STATE: ;
					default: bresp_next = `FRCM_RESP_SLVERR;
				endcase
			end else if (aw_addr_reg > `FRCM_REG_STATE || aw_addr_reg[1:0] != 2'h0) begin
				bresp_next = `FRCM_RESP_SLVERR;
			end
		end
		// Read channel; an error read during switchover waits with busy low.
		unique case (rd_state_reg)
			FRCM_RD_IDLE: begin
				if (s_axi_arvalid && arready_reg) begin
					ar_addr_next = s_axi_araddr;
					if (s_axi_araddr == `FRCM_REG_ERR && osc.switching) begin
						rd_state_next = FRCM_RD_HOLD;
						busy_n_next = 1'h0;
					end else begin
						rd_state_next = FRCM_RD_RESP;
						rvalid_next = 1'h1;
						rdata_next = rd_word;
						rresp_next = rd_ok ? `FRCM_RESP_OKAY : `FRCM_RESP_SLVERR;
					end
				end
			end
			FRCM_RD_HOLD: begin
				if (!osc.switching) begin
					rd_state_next = FRCM_RD_RESP;
					busy_n_next = 1'h1;
					rvalid_next = 1'h1;
					rdata_next = rd_word;
					rresp_next = `FRCM_RESP_OKAY;
				end
			end
			FRCM_RD_RESP: begin
				if (s_axi_rready) begin
					rd_state_next = FRCM_RD_IDLE;
					rvalid_next = 1'h0;
				end
			end
		endcase
		if (wr_ctrl && wdat_reg[`FRCM_CTRL_REC_EN]) begin
			sup_next = 1'h1;
		end
		if (run_reg) begin
			cnt_next = cnt_reg + 32'h1;
		end
		if (ovf) begin
			run_next = 1'h0;
			cnt_next = 32'h0;
			err_next[`FRCM_ERR_REC] = 1'h1;
			ist_next[`FRCM_ERR_REC] = 1'h1;
		end
		if (wr_err) begin
			run_next = 1'h0;
			cnt_next = 32'h0;
			err_next = err_next & {1'h0, ovf};
		end
		if (start) begin
			run_next = 1'h1;
			if (!run_reg || wr_err) begin
				cnt_next = 32'h0;
			end
		end
		if (osc.stopped && ctrl_reg[`FRCM_CTRL_OSC_EN]) begin
			err_next[`FRCM_ERR_CLK] = 1'h1;
		end
		if (osc.stop_pulse && ctrl_reg[`FRCM_CTRL_OSC_EN]) begin
			ist_next[`FRCM_ERR_CLK] = 1'h1;
		end
		if (ovf_stby) begin
			ctrl_next = 2'h0;
			sup_next = 1'h0;
			run_next = 1'h0;
			cnt_next = 32'h0;
			stby_next = 1'h1;
		end
		awready_next = !aw_full_next;
		wready_next = !w_full_next;
		arready_next = rd_state_next == FRCM_RD_IDLE;
		irq_next = |(ist_next & imask_next);
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pin_next[i] = |(outsel_next[2 * i +: 2] & err_next);
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aw_full_reg <= 1'h0;
			w_full_reg <= 1'h0;
			aw_addr_reg <= 8'h0;
			wdat_reg <= 8'h0;
			wstb_reg <= 1'h0;
			ar_addr_reg <= 8'h0;
			awready_reg <= 1'h0;
			wready_reg <= 1'h0;
			arready_reg <= 1'h0;
			bvalid_reg <= 1'h0;
			bresp_reg <= 2'h0;
			rvalid_reg <= 1'h0;
			rresp_reg <= 2'h0;
			rdata_reg <= 32'h0;
			rd_state_reg <= FRCM_RD_IDLE;
			busy_n_reg <= 1'h1;
			ctrl_reg <= 2'h0;
			cfg_reg <= `FRCM_CFG_RST;
			outsel_reg <= `FRCM_OUTSEL_RST;
			err_reg <= 2'h0;
			ist_reg <= 2'h0;
			imask_reg <= 2'h0;
			sup_reg <= 1'h0;
			run_reg <= 1'h0;
			cnt_reg <= 32'h0;
			stby_reg <= 1'h0;
			irq_reg <= 1'h0;
			pin_reg <= 2'h0;
			rc_reg <= 1'h0;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			aw_addr_reg <= aw_addr_next;
			wdat_reg <= wdat_next;
			wstb_reg <= wstb_next;
			ar_addr_reg <= ar_addr_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			arready_reg <= arready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			rd_state_reg <= rd_state_next;
			busy_n_reg <= busy_n_next;
			ctrl_reg <= ctrl_next;
			cfg_reg <= cfg_next;
			outsel_reg <= outsel_next;
			err_reg <= err_next;
			ist_reg <= ist_next;
			imask_reg <= imask_next;
			sup_reg <= sup_next;
			run_reg <= run_next;
			cnt_reg <= cnt_next;
			stby_reg <= stby_next;
			irq_reg <= irq_next;
			pin_reg <= pin_next;
			rc_reg <= osc.rc_sel;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign command_busy_n = busy_n_reg;
	assign use_rc_clock = rc_reg;
	assign standby_return = stby_reg;
	assign fault_indicator_pin = pin_reg;
	assign irq = irq_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_SUP_STICKY: assert property (@(posedge ref_clk) disable iff (srst) sup_reg && !ovf_stby |=> sup_reg)
		else $error("Supervision dropped without standby return");
	AST_RUN_CAUSE: assert property (@(posedge ref_clk) disable iff (srst) $rose(run_reg) |-> $past(start))
		else $error("Counter started without fault event");
	AST_CLR_HOLD: assert property (@(posedge ref_clk) disable iff (srst) wr_err && !start |=> !run_reg && cnt_reg == 32'h0)
		else $error("Counter not stopped by error clear");
	AST_OVF_ERR: assert property (@(posedge ref_clk) disable iff (srst) ovf |=> err_reg[`FRCM_ERR_REC])
		else $error("Overflow did not set the error bit");
	AST_CLR_ERR: assert property (@(posedge ref_clk) disable iff (srst) wr_err && !ovf |=> !err_reg[`FRCM_ERR_REC])
		else $error("Error clear left recovery error set");
	AST_STBY_CLR: assert property (@(posedge ref_clk) disable iff (srst) ovf_stby |=> standby_return && ctrl_reg == 2'h0)
		else $error("Standby return kept enable bits");
	AST_STBY_KEEP: assert property (@(posedge ref_clk) disable iff (srst)
		ovf_stby && !do_wr |=> $stable(outsel_reg) && err_reg[`FRCM_ERR_REC])
		else $error("Standby return changed kept state");
	AST_CLK_ERR: assert property (@(posedge ref_clk) disable iff (srst)
		osc.stopped && ctrl_reg[`FRCM_CTRL_OSC_EN] |=> err_reg[`FRCM_ERR_CLK])
		else $error("Clock stop error not set");
	AST_CLK_OFF: assert property (@(posedge ref_clk) disable iff (srst)
		!err_reg[`FRCM_ERR_CLK] && !ctrl_reg[`FRCM_CTRL_OSC_EN] |=> !err_reg[`FRCM_ERR_CLK])
		else $error("Clock stop error set while disabled");
	AST_BUSY_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
		rd_state_reg == FRCM_RD_HOLD |-> !command_busy_n && !s_axi_rvalid)
		else $error("Busy not low during held error read");
	AST_CNT_ZERO: assert property (@(posedge ref_clk) disable iff (srst) !run_reg |-> cnt_reg == 32'h0)
		else $error("Stopped counter not zero");
	AST_PIN_ROUTE: assert property (@(posedge ref_clk) disable iff (srst)
		##1 fault_indicator_pin[0] == |(outsel_reg[1:0] & err_reg))
		else $error("Fault pin does not follow selection");
endmodule // frcm_top

// ### design/frcm_params.svh
// Offsets, field positions, reset values and timing counts of the fault recovery clock monitor.
`ifndef FRCM_PARAMS_SVH
`define FRCM_PARAMS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define FRCM_CLK_MHZ 100
`define FRCM_T125_MS 125
`define FRCM_T500_MS 500
`define FRCM_T2S_MS 2000
`define FRCM_T4S_MS 4000
`define FRCM_MS_CYC(ms) ((ms) * 1000 * `FRCM_CLK_MHZ)
`define FRCM_SWITCH_US 500
`define FRCM_SWITCH_CYC (`FRCM_SWITCH_US * `FRCM_CLK_MHZ)
`define FRCM_OSC_STOP_NS 640
`define FRCM_OSC_STOP_CYC ((`FRCM_OSC_STOP_NS * `FRCM_CLK_MHZ + 999) / 1000)

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FRCM_REG_CTRL 8'h00
`define FRCM_REG_CFG 8'h04
`define FRCM_REG_ERR 8'h08
`define FRCM_REG_OUTSEL 8'h0c
`define FRCM_REG_IRQ_STAT 8'h10
`define FRCM_REG_IRQ_MASK 8'h14
`define FRCM_REG_STATE 8'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FRCM_CTRL_REC_EN 0
`define FRCM_CTRL_OSC_EN 1
`define FRCM_CFG_PER_LSB 0
`define FRCM_CFG_ACT_BIT 2
`define FRCM_ERR_REC 0
`define FRCM_ERR_CLK 1
`define FRCM_CFG_RST 3'h2
`define FRCM_OUTSEL_RST 4'h0
`define FRCM_RESP_OKAY 2'h0
`define FRCM_RESP_SLVERR 2'h2

`endif

// ### design/frcm_pkg.sv
// Types shared by the fault recovery clock monitor modules.
package frcm_pkg;
	typedef enum {FRCM_RD_IDLE, FRCM_RD_HOLD, FRCM_RD_RESP} frcm_rd_state_t;
	typedef logic [1:0] frcm_err_t;
endpackage

// ### design/frcm_osc_if.sv
// Interface carrying resonator watch results from the monitor to the core.
`timescale 1ns/100ps
interface frcm_osc_if;
	logic stopped;
	logic stop_pulse;
	logic switching;
	logic rc_sel;
	modport mon (output stopped, output stop_pulse, output switching, output rc_sel);
	modport core (input stopped, input stop_pulse, input switching, input rc_sel);
endinterface

// ### design/frcm_osc_mon.sv
// Resonator stop detector with automatic switch to the internal RC clock.
`timescale 1ns/100ps
`include "frcm_params.svh"
module frcm_osc_mon import frcm_pkg::*; #(
	parameter int unsigned STOP_CYC = `FRCM_OSC_STOP_CYC,
	parameter int unsigned SWITCH_CYC = `FRCM_SWITCH_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic osc_clk_in,
	frcm_osc_if.mon osc
);
	// The switchover window must last at least the eight cycles that the busy assertion watches.
	if (STOP_CYC < 2 || SWITCH_CYC < 8) begin : g_chk
		$error("frcm_osc_mon: counts too small");
	end

	logic sync1_reg, sync2_reg, last_reg;
	logic stopped_reg, stopped_next, pulse_reg, pulse_next, rc_reg, rc_next;
	logic [31:0] idle_reg, idle_next, sw_reg, sw_next;
	logic edge_seen;

	// ----------------------------------------
	// Synchroniser
	// ----------------------------------------
	// Only the second stage is read by logic; the first one just settles.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sync1_reg <= 1'h0;
			sync2_reg <= 1'h0;
			last_reg <= 1'h0;
		end else begin
			sync1_reg <= osc_clk_in;
			sync2_reg <= sync1_reg;
			last_reg <= sync2_reg;
		end
	end
	assign edge_seen = sync2_reg ^ last_reg;

	// ----------------------------------------
	// Stop detection and switchover
	// ----------------------------------------
	// The RC selection is kept once taken; returning to the resonator needs a reset,
	// so a flaky resonator cannot toggle the clock source back and forth.
	always_comb begin
		stopped_next = stopped_reg;
		pulse_next = 1'h0;
		rc_next = rc_reg;
		idle_next = idle_reg;
		sw_next = (sw_reg != 32'h0) ? sw_reg - 32'h1 : 32'h0;
		if (edge_seen) begin
			idle_next = 32'h0;
			stopped_next = 1'h0;
		end else if (idle_reg == STOP_CYC - 1) begin
			if (!stopped_reg) begin
				stopped_next = 1'h1;
				pulse_next = 1'h1;
				rc_next = 1'h1;
				if (!rc_reg) begin
					sw_next = SWITCH_CYC;
				end
			end
		end else begin
			idle_next = idle_reg + 32'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stopped_reg <= 1'h0;
			pulse_reg <= 1'h0;
			rc_reg <= 1'h0;
			idle_reg <= 32'h0;
			sw_reg <= 32'h0;
		end else begin
			stopped_reg <= stopped_next;
			pulse_reg <= pulse_next;
			rc_reg <= rc_next;
			idle_reg <= idle_next;
			sw_reg <= sw_next;
		end
	end

	assign osc.stopped = stopped_reg;
	assign osc.stop_pulse = pulse_reg;
	assign osc.switching = (sw_reg != 32'h0);
	assign osc.rc_sel = rc_reg;

	AST_RC_ON_STOP: assert property (@(posedge ref_clk) disable iff (srst) $rose(stopped_reg) |-> rc_reg)
		else $error("RC clock not selected at resonator stop");
	AST_SWITCH_BUSY: assert property (@(posedge ref_clk) disable iff (srst)
		pulse_reg && $rose(rc_reg) |-> (sw_reg != 32'h0) [*8])
		else $error("Switchover window ended too early");
endmodule // frcm_osc_mon

// ### test/frcm_resonator.sv
// Resonator model: a 160 ns clock on the oscillator pin that the bench can stop.
`timescale 1ns/100ps
module frcm_resonator (
	output logic osc_clk,
	input wire logic run
);
	// ----------------------------------------
	// Oscillation
	// ----------------------------------------
	// A dead crystal gives no edges, so a stopped resonator rests low instead of toggling.
	initial osc_clk = 1'b0;
	always begin
		#80;
		osc_clk = run ? ~osc_clk : 1'b0;
	end
endmodule // frcm_resonator

// ### test/frcm_top_test.sv
// Self-checking bench for the fault recovery clock monitor top level.
`timescale 1ns/100ps
`include "frcm_params.svh"
module frcm_top_test import frcm_pkg::*;;
	localparam int P0 = 20;
	localparam int P1 = 40;
	localparam int P2 = 60;
	localparam int P3 = 80;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic fault_event = 1'b0;
	logic osc_run = 1'b1;
	logic osc_clk;
	logic awready, wready, bvalid, arready, rvalid, command_busy_n, use_rc_clock, standby_return, irq;
	logic [1:0] bresp, rresp, fault_indicator_pin;
	logic [31:0] rdata;
	int miscompares = 0;
	int checked = 0;
	int busy_low = 0;
	int standby_seen = 0;
	int per[4] = '{P0, P1, P2, P3};
	int k;
	int n;
	int b0;

	// ----------------------------------------
	// Clock, partner and design
	// ----------------------------------------
	always #5 ref_clk = ~ref_clk;
	frcm_resonator u_frcm_resonator (.osc_clk(osc_clk), .run(osc_run));
	frcm_top #(.PER_125_CYC(P0), .PER_500_CYC(P1), .PER_2S_CYC(P2), .PER_4S_CYC(P3), .SWITCH_CYC(30),
		.STOP_CYC(64)) u_frcm_top (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.fault_event(fault_event), .osc_clk_in(osc_clk), .command_busy_n(command_busy_n),
		.use_rc_clock(use_rc_clock), .standby_return(standby_return),
		.fault_indicator_pin(fault_indicator_pin), .irq(irq));

	// Busy and standby pulses are short, so they are counted as they happen.
	always @(posedge ref_clk) begin
		if (command_busy_n === 1'b0) busy_low++;
		if (standby_return === 1'b1) standby_seen++;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Each channel is held until its own ready; one idle edge follows so no signal is set twice at once.
	// The wait has no limit of its own: only the watchdog ends a hung transfer.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		check("write resp", bresp, `FRCM_RESP_OKAY);
		bready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		check($sformatf("read %h", a), rdata, exp);
		check("read resp", rresp, er);
		rready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic pulse();
		fault_event <= 1'b1;
		@(posedge ref_clk);
		fault_event <= 1'b0;
		@(posedge ref_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		rd_chk(`FRCM_REG_CFG, 32'h2, 2'h0);
		rd_chk(`FRCM_REG_OUTSEL, 32'h0, 2'h0);
		rd_chk(8'h1c, 32'h0, `FRCM_RESP_SLVERR);
		// A write with the low strobe off must leave the configuration alone.
		wstrb <= 4'h0;
		wr(`FRCM_REG_CFG, 32'h0);
		wstrb <= 4'hf;
		rd_chk(`FRCM_REG_CFG, 32'h2, 2'h0);
		pulse();
		rd_chk(`FRCM_REG_STATE, 32'h0, 2'h0);
		$display("Test reset done");
	endtask

	task automatic test_clear();
		wr(`FRCM_REG_CTRL, 32'h1);
		wr(`FRCM_REG_CTRL, 32'h0);
		rd_chk(`FRCM_REG_STATE, 32'h1, 2'h0);
		pulse();
		rd_chk(`FRCM_REG_STATE, 32'h3, 2'h0);
		wr(`FRCM_REG_ERR, 32'h0);
		rd_chk(`FRCM_REG_STATE, 32'h1, 2'h0);
		repeat (100) @(posedge ref_clk);
		rd_chk(`FRCM_REG_ERR, 32'h0, 2'h0);
		$display("Test clear done");
	endtask

	task automatic test_periods();
		wr(`FRCM_REG_IRQ_MASK, 32'h1);
		wr(`FRCM_REG_OUTSEL, 32'h1);
		for (k = 0; k < 4; k++) begin
			wr(`FRCM_REG_CFG, k);
			wr(`FRCM_REG_ERR, 32'h0);
			wr(`FRCM_REG_IRQ_STAT, 32'h3);
			check("irq idle", irq, 1'b0);
			pulse();
			for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge ref_clk);
			check("period", n >= per[k] - 1 && n <= per[k] + 3, 1'b1);
			rd_chk(`FRCM_REG_ERR, 32'h1, 2'h0);
			check("pins", fault_indicator_pin, 2'b01);
		end
		check("no standby", standby_seen, 0);
		wr(`FRCM_REG_IRQ_MASK, 32'h0);
		check("irq masked", irq, 1'b0);
		wr(`FRCM_REG_IRQ_MASK, 32'h1);
		check("irq unmasked", irq, 1'b1);
		wr(`FRCM_REG_IRQ_STAT, 32'h1);
		check("irq cleared", irq, 1'b0);
		$display("Test periods done");
	endtask

	task automatic test_standby();
		wr(`FRCM_REG_CTRL, 32'h3);
		wr(`FRCM_REG_OUTSEL, 32'h6);
		wr(`FRCM_REG_CFG, 32'h4);
		wr(`FRCM_REG_ERR, 32'h0);
		pulse();
		for (n = 0; n < 200 && standby_seen == 0; n++) @(posedge ref_clk);
		check("standby", standby_seen, 1);
		rd_chk(`FRCM_REG_CTRL, 32'h0, 2'h0);
		rd_chk(`FRCM_REG_ERR, 32'h1, 2'h0);
		rd_chk(`FRCM_REG_OUTSEL, 32'h6, 2'h0);
		check("pins", fault_indicator_pin, 2'b10);
		$display("Test standby done");
	endtask

	task automatic test_stop(input logic en);
		wr(`FRCM_REG_CTRL, {en, 1'b0});
		wr(`FRCM_REG_ERR, 32'h0);
		osc_run <= 1'b0;
		for (n = 0; n < 300 && use_rc_clock !== 1'b1; n++) @(posedge ref_clk);
		check("rc clock", use_rc_clock, 1'b1);
		b0 = busy_low;
		rd_chk(`FRCM_REG_ERR, {en, 1'b0}, 2'h0);
		check("busy held", busy_low > b0, 1'b1);
		wr(`FRCM_REG_ERR, 32'h0);
		rd_chk(`FRCM_REG_ERR, {en, 1'b0}, 2'h0);
		// With detection off the clear must drop the bit while the resonator stays dead.
		wr(`FRCM_REG_CTRL, 32'h0);
		wr(`FRCM_REG_ERR, 32'h0);
		rd_chk(`FRCM_REG_ERR, 32'h0, 2'h0);
		$display("Test stop done");
	endtask

	task automatic print_verdict();
		$display("Checks %0d, miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	// The rc selection only clears by reset, so the enabled stop case runs after a second reset.
	initial begin
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		test_reset();
		test_clear();
		test_periods();
		test_standby();
		test_stop(1'b0);
		osc_run <= 1'b1;
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		test_stop(1'b1);
		print_verdict();
	end

	// Tests take about 800 cycles; this limit only trips on a hang.
	initial begin
		#200000;
		miscompares++;
		print_verdict();
	end
endmodule // frcm_top_test
